//--- dv/dtp_ext_model.sv
`timescale 1ns/100ps
`default_nettype none
module dtp_ext_model (
	input  wire logic       clk,
	input  wire logic       osc_run,
	input  wire logic       go,
	input  wire logic [7:0] n_pulse,
	output logic            osc,
	output logic            pin,
	output logic            busy
);
	// ==========================================================
	// Watch crystal, 500 ns period, phase offset from the CPU clock
	initial begin
		osc = 1'b0;
		#7;
		forever begin
			#250 osc = osc_run ? ~osc : 1'b0;
		end
	end

	// ==========================================================
	// Count pin pulses, each level held two CPU cycles
	initial begin
		pin = 1'b0;
		busy = 1'b0;
	end
	always @(posedge clk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			for (int i = 0; i < n_pulse; i++) begin
				repeat (2) @(posedge clk);
				pin <= 1'b1;
				repeat (2) @(posedge clk);
				pin <= 1'b0;
			end
			busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- dv/dtp_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module dtp_top_bench;
	logic       CLOCK = 1'b0;
	logic       RESET = 1'b1;
	logic       WRITE = 1'b0;
	logic       READ = 1'b0;
	logic [5:0] ADDR = 6'h00;
	logic [7:0] WDATA = 8'h00;
	logic [7:0] RDATA;
	logic       ZERO_PIN_DIR = 1'b0;
	logic       TWO_PIN_DIR = 1'b0;
	logic [3:0] VECTOR_ACK = 4'h0;
	logic       pin0, oe0, pin2, oe2, osc, cpin, busy;
	logic       osc_run = 1'b0;
	logic       go = 1'b0;
	logic [7:0] npulse = 8'h00;
	int         n_fail = 0;
	int         checked = 0;
	int         div0 [7] = '{1, 8, 32, 64, 128, 256, 1024};
	int         div2 [5] = '{1, 8, 64, 256, 1024};
	logic [5:0] regs [9] = '{6'h23, 6'h24, 6'h25, 6'h30, 6'h31, 6'h32,
		6'h33, 6'h36, 6'h3F};

	// ==========================================================
	// Clock, design and far side
	always #25 CLOCK = ~CLOCK;
	dtp_top dut (.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
		.WRITE(WRITE), .READ(READ), .RDATA(RDATA), .LOW_FREQ_OSC_IN(osc),
		.TIMER_TWO_COUNT_PIN(cpin), .ZERO_PIN_DIR(ZERO_PIN_DIR),
		.TWO_PIN_DIR(TWO_PIN_DIR), .VECTOR_ACK(VECTOR_ACK),
		.TIMER_ZERO_COMPARE_PIN(pin0), .TIMER_ZERO_COMPARE_OE(oe0),
		.TIMER_TWO_COMPARE_PIN(pin2), .TIMER_TWO_COMPARE_OE(oe2));
	dtp_ext_model ext (.clk(CLOCK), .osc_run(osc_run), .go(go),
		.n_pulse(npulse), .osc(osc), .pin(cpin), .busy(busy));

	// ==========================================================
	// Bus cycles, pulses and comparisons
	task wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WRITE <= 1'b1;
		@(posedge CLOCK);
		WRITE <= 1'b0;
	endtask
	task rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		READ <= 1'b1;
		@(posedge CLOCK);
		READ <= 1'b0;
		#1 d = RDATA;
	endtask
	task chk(input string nm, input logic [7:0] lo, input logic [7:0] hi,
		input logic [7:0] got);
		checked++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_fail++;
			$display("ERROR %s expected %0h..%0h seen %0h", nm, lo, hi, got);
		end
	endtask
	task pulse(input logic [7:0] n);
		@(posedge CLOCK);
		npulse <= n;
		go <= 1'b1;
		@(posedge CLOCK);
		go <= 1'b0;
		#1;
		for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge CLOCK) #1;
		repeat (4) @(posedge CLOCK);
	endtask
	task run_div(input logic [5:0] ca, input logic [5:0] na,
		input logic [2:0] cs, input int dv);
		int w;
		logic [7:0] d;
		w = (dv == 1) ? 40 : dv * 10;
		wr(na, 8'h00);
		wr(ca, {5'h00, cs});
		repeat (w) @(posedge CLOCK);
		wr(ca, 8'h00);
		rd(na, d);
		chk("divided count", 8'(w / dv - 1), 8'(w / dv + 3), d);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		#(60000 * 50);
		n_fail++;
		print_verdict;
	end

	// ==========================================================
	// Test sequence
	initial begin
		logic [7:0] d;
		int hi, lo, top, dn;
		logic [7:0] prev;
		repeat (12) @(posedge CLOCK);
		RESET <= 1'b0;
		foreach (regs[i]) begin
			rd(regs[i], d);
			chk("reset value", 8'h00, 8'h00, d);
		end
		wr(6'h24, 8'h5A);
		repeat (3) @(posedge CLOCK);
		rd(6'h24, d);
		chk("stopped count", 8'h5A, 8'h5A, d);
		wr(6'h25, 8'hF8);
		rd(6'h25, d);
		chk("t2 control", 8'h78, 8'h78, d);
		wr(6'h33, 8'hF8);
		rd(6'h33, d);
		chk("t0 control", 8'h78, 8'h78, d);
		wr(6'h25, 8'h00);
		wr(6'h33, 8'h00);
		$display("test registers done");
		for (int c = 1; c < 8; c++) run_div(6'h33, 6'h32, c, div0[c-1]);
		for (int c = 1; c < 6; c++) run_div(6'h25, 6'h24, c, div2[c-1]);
		$display("test prescalers done");
		wr(6'h23, 8'h03);
		wr(6'h24, 8'h00);
		wr(6'h36, 8'hC3);
		wr(6'h25, 8'h09);
		repeat (8) begin
			rd(6'h24, d);
			chk("clear on match count", 8'h00, 8'h03, d);
		end
		wr(6'h25, 8'h00);
		rd(6'h36, d);
		chk("match flag", 8'h01, 8'h01, {7'h00, d[7]});
		wr(6'h36, 8'hC3);
		rd(6'h36, d);
		chk("flag cleared", 8'h00, 8'h00, d);
		wr(6'h25, 8'h01);
		wr(6'h24, 8'hFD);
		repeat (8) @(posedge CLOCK);
		wr(6'h25, 8'h00);
		rd(6'h24, d);
		chk("free count", 8'h05, 8'h0C, d);
		rd(6'h36, d);
		chk("wrap and match", 8'hC0, 8'hC0, d);
		@(posedge CLOCK) VECTOR_ACK <= 4'h4;
		@(posedge CLOCK) VECTOR_ACK <= 4'h0;
		rd(6'h36, d);
		chk("wrap acknowledged", 8'h80, 8'h80, d);
		$display("test match and flags done");
		wr(6'h30, 8'h08);
		for (int k = 0; k < 2; k++) begin
			osc_run <= (k == 1);
			wr(6'h32, 8'h00);
			wr(6'h33, 8'h01);
			repeat (200) @(posedge CLOCK);
			wr(6'h33, 8'h00);
			rd(6'h32, d);
			chk("osc count", k ? 8'h11 : 8'h00, k ? 8'h16 : 8'h00, d);
		end
		osc_run <= 1'b0;
		wr(6'h30, 8'h00);
		$display("test async clock done");
		TWO_PIN_DIR <= 1'b1;
		for (int k = 6; k < 8; k++) begin
			wr(6'h24, 8'h00);
			wr(6'h25, 8'(k));
			pulse(8'(k - 2));
			wr(6'h25, 8'h00);
			rd(6'h24, d);
			chk("pin edges", 8'(k - 2), 8'(k - 2), d);
		end
		$display("test count pin done");
		ZERO_PIN_DIR <= 1'b1;
		wr(6'h31, 8'h05);
		wr(6'h32, 8'h00);
		for (int m = 0; m < 4; m++) begin
			wr(6'h33, {2'b00, 2'(m), 4'h9});
			repeat (12) @(posedge CLOCK);
			hi = 0;
			lo = 0;
			repeat (20) begin
				@(posedge CLOCK) #1;
				if (pin0 === 1'b1) hi++;
				if (pin0 === 1'b0) lo++;
			end
			chk("t0 drive", 8'(m != 0), 8'(m != 0), {7'h00, oe0});
			if (m == 1) chk("toggle", 8'h02, 8'h02, 8'((hi > 0) + (lo > 0)));
			if (m == 2) chk("clear", 8'h00, 8'h00, 8'(hi));
			if (m == 3) chk("set", 8'h00, 8'h00, 8'(lo));
		end
		ZERO_PIN_DIR <= 1'b0;
		repeat (3) @(posedge CLOCK) #1;
		chk("t0 direction", 8'h00, 8'h00, {7'h00, oe0});
		rd(6'h36, d);
		chk("t0 match flag", 8'h82, 8'h82, d);
		wr(6'h33, 8'h00);
		$display("test compare output done");
		wr(6'h23, 8'h80);
		wr(6'h24, 8'h00);
		for (int m = 2; m < 4; m++) begin
			wr(6'h25, {2'b01, 2'(m), 4'h9});
			top = 0;
			dn = 0;
			prev = 8'h00;
			for (int i = 0; i < 400; i++) begin
				rd(6'h24, d);
				if (d >= 8'hF0) top++;
				if (d < prev) dn++;
				prev = d;
				if (i > 260 && d > 8'h90) chk("pwm high side", 8'(m == 3), 8'(m == 3), {7'h00, pin2});
				if (i > 260 && d < 8'h70) chk("pwm low side", 8'(m == 2), 8'(m == 2), {7'h00, pin2});
			end
			chk("pwm top and fall", 8'h01, 8'h01, 8'(top > 0 && dn > 0));
			chk("t2 drive", 8'h01, 8'h01, {7'h00, oe2});
		end
		wr(6'h25, 8'h00);
		$display("test pulse mode done");
		print_verdict;
	end
endmodule
`default_nettype wire

//--- dv/dtp_top_checker.sv
`timescale 1ns/100ps
`default_nettype none
module dtp_top_checker (
	input wire logic       CLOCK,
	input wire logic       RESET,
	input wire logic [5:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WRITE,
	input wire logic       READ,
	input wire logic [7:0] RDATA,
	input wire logic       LOW_FREQ_OSC_IN,
	input wire logic       TIMER_TWO_COUNT_PIN,
	input wire logic       ZERO_PIN_DIR,
	input wire logic       TWO_PIN_DIR,
	input wire logic [3:0] VECTOR_ACK,
	input wire logic       TIMER_ZERO_COMPARE_PIN,
	input wire logic       TIMER_ZERO_COMPARE_OE,
	input wire logic       TIMER_TWO_COMPARE_PIN,
	input wire logic       TIMER_TWO_COMPARE_OE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);

	// ==========================================================
	// Shadow of software writes
	logic [6:0] ctl0_ff;
	logic [6:0] ctl2_ff;
	logic [7:0] cnt2_ff;
	logic       async_ff;
	logic       still_ff;
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			ctl0_ff <= 7'h00;
			ctl2_ff <= 7'h00;
			cnt2_ff <= 8'h00;
			async_ff <= 1'b0;
			still_ff <= 1'b0;
		end else if (WRITE) begin
			case (ADDR)
				6'h33: ctl0_ff <= WDATA[6:0];
				6'h30: async_ff <= WDATA[3];
				6'h25: begin
					ctl2_ff <= WDATA[6:0];
					if (WDATA[2:0] != 3'h0) still_ff <= 1'b0;
				end
				6'h24: begin
					cnt2_ff <= WDATA;
					still_ff <= (ctl2_ff[2:0] == 3'h0);
				end
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Register bus and pin checks
	a_rdata_idle_zero: assert property (!READ |=> RDATA == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_reads_zero: assert property (READ && !(ADDR inside {6'h23,
		6'h24, 6'h25, 6'h30, 6'h31, 6'h32, 6'h33, 6'h36}) |=> RDATA == 8'h00)
		else $error("unmapped address read nonzero");
	a_ctrl0_read_back: assert property (READ && ADDR == 6'h33
		|=> RDATA == {1'b0, ctl0_ff}) else $error("timer zero control bad");
	a_ctrl2_read_back: assert property (READ && ADDR == 6'h25
		|=> RDATA == {1'b0, ctl2_ff}) else $error("timer two control bad");
	a_async_sel_read: assert property (READ && ADDR == 6'h30
		|=> RDATA == {4'h0, async_ff, 3'h0}) else $error("async status bad");
	a_stop_holds_count: assert property (still_ff && READ &&
		ADDR == 6'h24 |=> RDATA == cnt2_ff) else $error("stopped count moved");
	a_zero_oe_off: assert property (!ZERO_PIN_DIR ||
		ctl0_ff[5:4] == 2'h0 || ctl0_ff[6:4] == 3'h5
		|=> !TIMER_ZERO_COMPARE_OE) else $error("timer zero pin driven");
	a_two_oe_off: assert property (!TWO_PIN_DIR ||
		ctl2_ff[5:4] == 2'h0 || ctl2_ff[6:4] == 3'h5
		|=> !TIMER_TWO_COMPARE_OE) else $error("timer two pin driven");
	a_zero_oe_on: assert property (ZERO_PIN_DIR && ctl0_ff[5]
		|=> TIMER_ZERO_COMPARE_OE) else $error("timer zero pin not driven");
endmodule
bind dtp_top dtp_top_checker chk (.CLOCK(CLOCK), .RESET(RESET),
	.ADDR(ADDR), .WDATA(WDATA), .WRITE(WRITE), .READ(READ), .RDATA(RDATA),
	.LOW_FREQ_OSC_IN(LOW_FREQ_OSC_IN),
	.TIMER_TWO_COUNT_PIN(TIMER_TWO_COUNT_PIN),
	.ZERO_PIN_DIR(ZERO_PIN_DIR), .TWO_PIN_DIR(TWO_PIN_DIR),
	.VECTOR_ACK(VECTOR_ACK), .TIMER_ZERO_COMPARE_PIN(TIMER_ZERO_COMPARE_PIN),
	.TIMER_ZERO_COMPARE_OE(TIMER_ZERO_COMPARE_OE),
	.TIMER_TWO_COMPARE_PIN(TIMER_TWO_COMPARE_PIN),
	.TIMER_TWO_COMPARE_OE(TIMER_TWO_COMPARE_OE));
`default_nettype wire

//--- hdl/dtp_channel.v
`timescale 1ns/100ps
`default_nettype none
`include "dtp_map.vh"

module dtp_channel (
	input  wire       clk,
	input  wire       reset,
	input  wire       tick,
	input  wire       pwm_en,
	input  wire [1:0] out_mode,
	input  wire       clear_on_match,
	input  wire       cnt_wr,
	input  wire       cmp_wr,
	input  wire [7:0] wdata,
	output reg  [7:0] count_ff,
	output reg  [7:0] cmp_buf_ff,
	output reg        match_ff,
	output reg        wrap_ff,
	output reg        pin_ff
);

	reg  [7:0] cmp_act_ff;
	reg        up_ff;
	reg        match_up_ff;
	reg  [7:0] nxt_count;
	reg        nxt_up;
	reg        nxt_pin;
	wire       clr_now;
	wire       stepped;

	// Clear on match acts only outside pulse mode
	assign clr_now = match_ff & clear_on_match & ~pwm_en;
	assign stepped = tick & ~cnt_wr & ~clr_now;

	// ==========================================================
	// Next count: load, clear, up or up/down step
	always @* begin
		nxt_count = count_ff;
		nxt_up    = up_ff;
		if (cnt_wr) begin
			nxt_count = wdata;
		end else if (clr_now) begin
			nxt_count = `DTP_CNT_BOTTOM;
		end else if (tick) begin
			if (!pwm_en) begin
				nxt_count = count_ff + `DTP_CNT_ONE;
			end else if (up_ff) begin
				if (count_ff == `DTP_CNT_TOP) begin
					nxt_count = `DTP_CNT_BELOW_TOP;
					nxt_up    = 1'b0;
				end else begin
					nxt_count = count_ff + `DTP_CNT_ONE;
				end
			end else begin
				if (count_ff == `DTP_CNT_BOTTOM) begin
					nxt_count = `DTP_CNT_ONE;
					nxt_up    = 1'b1;
				end else begin
					nxt_count = count_ff - `DTP_CNT_ONE;
				end
			end
		end
		if (!pwm_en) begin
			nxt_up = 1'b1;
		end
	end

	// Pin action on a match
	always @* begin
		nxt_pin = pin_ff;
		if (match_ff) begin
			if (pwm_en) begin
				case (out_mode)
				`DTP_MODE_CLEAR: nxt_pin = ~match_up_ff;
				`DTP_MODE_SET:   nxt_pin = match_up_ff;
				default:         nxt_pin = pin_ff;
				endcase
			end else begin
				case (out_mode)
				`DTP_MODE_TOGGLE: nxt_pin = ~pin_ff;
				`DTP_MODE_CLEAR:  nxt_pin = 1'b0;
				`DTP_MODE_SET:    nxt_pin = 1'b1;
				default:          nxt_pin = pin_ff;
				endcase
			end
		end
	end

	// ==========================================================
	// State registers
	always @(posedge clk) begin
		if (reset) begin
			count_ff    <= `DTP_CNT_BOTTOM;
			cmp_buf_ff  <= `DTP_BYTE_ZERO;
			cmp_act_ff  <= `DTP_BYTE_ZERO;
			up_ff       <= 1'b1;
			match_ff    <= 1'b0;
			match_up_ff <= 1'b0;
			wrap_ff     <= 1'b0;
			pin_ff      <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			up_ff    <= nxt_up;
			if (cmp_wr) begin
				cmp_buf_ff <= wdata;
			end
			// Pulse mode takes a new compare value only at the top
			if (!pwm_en || (tick && count_ff == `DTP_CNT_TOP)) begin
				cmp_act_ff <= cmp_buf_ff;
			end
			// Match only when a step reaches the compare value
			match_ff    <= stepped & (nxt_count == cmp_act_ff);
			match_up_ff <= up_ff;
			wrap_ff     <= stepped & (pwm_en ?
				(count_ff == `DTP_CNT_BOTTOM) :
				(count_ff == `DTP_CNT_TOP));
			pin_ff <= nxt_pin;
		end
	end

endmodule
`default_nettype wire

//--- hdl/dtp_map.vh
`ifndef DTP_MAP_VH
`define DTP_MAP_VH

// ==========================================================
// Register addresses
`define DTP_ADDR_T2_CMP        6'h23
`define DTP_ADDR_T2_COUNT      6'h24
`define DTP_ADDR_T2_CTRL       6'h25
`define DTP_ADDR_ASYNC_STAT    6'h30
`define DTP_ADDR_T0_CMP        6'h31
`define DTP_ADDR_T0_COUNT      6'h32
`define DTP_ADDR_T0_CTRL       6'h33
`define DTP_ADDR_FLAGS         6'h36

// ==========================================================
// Control register fields
`define DTP_CTRL_PWM           6
`define DTP_CTRL_MODE_HI       5
`define DTP_CTRL_MODE_LO       4
`define DTP_CTRL_CTC           3
`define DTP_CTRL_CS_HI         2
`define DTP_CTRL_CS_LO         0
`define DTP_CTRL_RESET         7'h00

// ==========================================================
// Async status and flag register fields
`define DTP_ASYNC_SEL          3
`define DTP_FLAG_T0_WRAP       0
`define DTP_FLAG_T0_MATCH      1
`define DTP_FLAG_T2_WRAP       6
`define DTP_FLAG_T2_MATCH      7
`define DTP_FLAGS_RESET        4'h0

// ==========================================================
// Clock select and output mode codes
`define DTP_CS_STOP            3'h0
`define DTP_CS_DIV1            3'h1
`define DTP_CS_SEL2            3'h2
`define DTP_CS_SEL3            3'h3
`define DTP_CS_SEL4            3'h4
`define DTP_CS_SEL5            3'h5
`define DTP_CS_SEL6            3'h6
`define DTP_CS_SEL7            3'h7
`define DTP_MODE_OFF           2'h0
`define DTP_MODE_TOGGLE        2'h1
`define DTP_MODE_CLEAR         2'h2
`define DTP_MODE_SET           2'h3

// ==========================================================
// Prescaler tap indices (divide by two to the index)
`define DTP_TAP_1              0
`define DTP_TAP_8              3
`define DTP_TAP_32             5
`define DTP_TAP_64             6
`define DTP_TAP_128            7
`define DTP_TAP_256            8
`define DTP_TAP_1024           10
`define DTP_PRE_BITS           10

// ==========================================================
// Count values
`define DTP_CNT_TOP            8'hFF
`define DTP_CNT_BOTTOM         8'h00
`define DTP_CNT_ONE            8'h01
`define DTP_CNT_BELOW_TOP      8'hFE
`define DTP_BYTE_ZERO          8'h00

`endif

//--- hdl/dtp_prescaler.v
`timescale 1ns/100ps
`default_nettype none
`include "dtp_map.vh"

module dtp_prescaler (
	input  wire                    clk,
	input  wire                    reset,
	input  wire                    en,
	output wire [`DTP_PRE_BITS:0]  tap
);

	reg  [`DTP_PRE_BITS-1:0] cnt_ff;
	wire [`DTP_PRE_BITS-1:0] nxt_cnt;

	// ==========================================================
	// Free-running divider, advanced by the input enable
	assign nxt_cnt = en ? cnt_ff + 1'b1 : cnt_ff;

	always @(posedge clk) begin
		if (reset) begin
			cnt_ff <= {`DTP_PRE_BITS{1'b0}};
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Tap k pulses once every two to the k input pulses
	assign tap[0] = en;
	genvar k;
	generate
		for (k = 1; k <= `DTP_PRE_BITS; k = k + 1) begin : g_tap
			assign tap[k] = en & (&cnt_ff[k-1:0]);
		end
	endgenerate

endmodule
`default_nettype wire

//--- hdl/dtp_top.v
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "dtp_map.vh"

module dtp_top (
	input  wire       CLOCK,
	input  wire       RESET,
	input  wire [5:0] ADDR,
	input  wire [7:0] WDATA,
	input  wire       WRITE,
	input  wire       READ,
	output reg  [7:0] RDATA,
	input  wire       LOW_FREQ_OSC_IN,
	input  wire       TIMER_TWO_COUNT_PIN,
	input  wire       ZERO_PIN_DIR,
	input  wire       TWO_PIN_DIR,
	input  wire [3:0] VECTOR_ACK,
	output wire       TIMER_ZERO_COMPARE_PIN,
	output reg        TIMER_ZERO_COMPARE_OE,
	output wire       TIMER_TWO_COMPARE_PIN,
	output reg        TIMER_TWO_COMPARE_OE
);

	// ==========================================================
	// Declarations
	reg  [6:0]  timer_zero_control_ff;
	reg  [6:0]  timer_two_control_ff;
	reg         async_sel_ff;
	reg  [3:0]  flags_ff;
	reg  [3:0]  nxt_flags;
	reg  [7:0]  nxt_rdata;
	reg         osc_sync1_ff;
	reg         osc_sync2_ff;
	reg         osc_prev_ff;
	reg         pin_sync1_ff;
	reg         pin_sync2_ff;
	reg         pin_prev_ff;
	wire        osc_rise;
	wire        pin_rise;
	wire        pin_fall;
	wire        zero_pre_en;
	wire [10:0] zero_taps;
	wire [10:0] shared_taps;
	wire        zero_tick;
	wire        two_tick;
	wire [7:0]  zero_count;
	wire [7:0]  two_count;
	wire [7:0]  zero_cmp;
	wire [7:0]  two_cmp;
	wire        zero_match;
	wire        two_match;
	wire        zero_wrap;
	wire        two_wrap;
	wire [3:0]  flag_set;
	wire [3:0]  flag_clr;
	wire        wr_zero_ctrl;
	wire        wr_two_ctrl;
	wire        wr_async;
	wire        wr_flags;

	// ==========================================================
	// Functions
	// Address match for a one-cycle write
	function wr_hit;
		input       strobe;
		input [5:0] addr;
		input [5:0] target;
		begin
			wr_hit = strobe & (addr == target);
		end
	endfunction

	// Timer zero clock selection from its prescaler taps
	function sel_zero;
		input [2:0]  cs;
		input [10:0] t;
		begin
			case (cs)
			`DTP_CS_DIV1: sel_zero = t[`DTP_TAP_1];
			`DTP_CS_SEL2: sel_zero = t[`DTP_TAP_8];
			`DTP_CS_SEL3: sel_zero = t[`DTP_TAP_32];
			`DTP_CS_SEL4: sel_zero = t[`DTP_TAP_64];
			`DTP_CS_SEL5: sel_zero = t[`DTP_TAP_128];
			`DTP_CS_SEL6: sel_zero = t[`DTP_TAP_256];
			`DTP_CS_SEL7: sel_zero = t[`DTP_TAP_1024];
			default:      sel_zero = 1'b0;
			endcase
		end
	endfunction

	// Timer two clock selection from shared taps and pin edges
	function sel_two;
		input [2:0]  cs;
		input [10:0] t;
		input        fall;
		input        rise;
		begin
			case (cs)
			`DTP_CS_DIV1: sel_two = t[`DTP_TAP_1];
			`DTP_CS_SEL2: sel_two = t[`DTP_TAP_8];
			`DTP_CS_SEL3: sel_two = t[`DTP_TAP_64];
			`DTP_CS_SEL4: sel_two = t[`DTP_TAP_256];
			`DTP_CS_SEL5: sel_two = t[`DTP_TAP_1024];
			`DTP_CS_SEL6: sel_two = fall;
			`DTP_CS_SEL7: sel_two = rise;
			default:      sel_two = 1'b0;
			endcase
		end
	endfunction

	// ==========================================================
	// Input synchronisers and edge detection
	// Second stage alone feeds the edge detectors
	always @(posedge CLOCK) begin
		if (RESET) begin
			osc_sync1_ff <= 1'b0;
			osc_sync2_ff <= 1'b0;
			osc_prev_ff  <= 1'b0;
			pin_sync1_ff <= 1'b0;
			pin_sync2_ff <= 1'b0;
			pin_prev_ff  <= 1'b0;
		end else begin
			osc_sync1_ff <= LOW_FREQ_OSC_IN;
			osc_sync2_ff <= osc_sync1_ff;
			osc_prev_ff  <= osc_sync2_ff;
			pin_sync1_ff <= TIMER_TWO_COUNT_PIN;
			pin_sync2_ff <= pin_sync1_ff;
			pin_prev_ff  <= pin_sync2_ff;
		end
	end

	// Edges seen one per level, so each level must last a cycle
	assign osc_rise = osc_sync2_ff & ~osc_prev_ff;
	assign pin_rise = pin_sync2_ff & ~pin_prev_ff;
	assign pin_fall = ~pin_sync2_ff & pin_prev_ff;

	// ==========================================================
	// Prescalers and clock selection
	// Timer zero input: every CPU cycle, or oscillator rising edges
	assign zero_pre_en = async_sel_ff ? osc_rise : 1'b1;

	dtp_prescaler u_zero_pre (
		.clk   (CLOCK),
		.reset (RESET),
		.en    (zero_pre_en),
		.tap   (zero_taps)
	);

	// Shared divider always runs from the CPU clock
	dtp_prescaler u_shared_pre (
		.clk   (CLOCK),
		.reset (RESET),
		.en    (1'b1),
		.tap   (shared_taps)
	);

	assign zero_tick = sel_zero(
		timer_zero_control_ff[`DTP_CTRL_CS_HI:`DTP_CTRL_CS_LO],
		zero_taps);
	assign two_tick = sel_two(
		timer_two_control_ff[`DTP_CTRL_CS_HI:`DTP_CTRL_CS_LO],
		shared_taps, pin_fall, pin_rise);

	// ==========================================================
	// Timer channels
	dtp_channel u_zero (
		.clk            (CLOCK),
		.reset          (RESET),
		.tick           (zero_tick),
		.pwm_en         (timer_zero_control_ff[`DTP_CTRL_PWM]),
		.out_mode       (timer_zero_control_ff[
			`DTP_CTRL_MODE_HI:`DTP_CTRL_MODE_LO]),
		.clear_on_match (timer_zero_control_ff[`DTP_CTRL_CTC]),
		.cnt_wr         (wr_hit(WRITE, ADDR, `DTP_ADDR_T0_COUNT)),
		.cmp_wr         (wr_hit(WRITE, ADDR, `DTP_ADDR_T0_CMP)),
		.wdata          (WDATA),
		.count_ff       (zero_count),
		.cmp_buf_ff     (zero_cmp),
		.match_ff       (zero_match),
		.wrap_ff        (zero_wrap),
		.pin_ff         (TIMER_ZERO_COMPARE_PIN)
	);

	dtp_channel u_two (
		.clk            (CLOCK),
		.reset          (RESET),
		.tick           (two_tick),
		.pwm_en         (timer_two_control_ff[`DTP_CTRL_PWM]),
		.out_mode       (timer_two_control_ff[
			`DTP_CTRL_MODE_HI:`DTP_CTRL_MODE_LO]),
		.clear_on_match (timer_two_control_ff[`DTP_CTRL_CTC]),
		.cnt_wr         (wr_hit(WRITE, ADDR, `DTP_ADDR_T2_COUNT)),
		.cmp_wr         (wr_hit(WRITE, ADDR, `DTP_ADDR_T2_CMP)),
		.wdata          (WDATA),
		.count_ff       (two_count),
		.cmp_buf_ff     (two_cmp),
		.match_ff       (two_match),
		.wrap_ff        (two_wrap),
		.pin_ff         (TIMER_TWO_COMPARE_PIN)
	);

	// ==========================================================
	// Register writes
	assign wr_zero_ctrl = wr_hit(WRITE, ADDR, `DTP_ADDR_T0_CTRL);
	assign wr_two_ctrl  = wr_hit(WRITE, ADDR, `DTP_ADDR_T2_CTRL);
	assign wr_async     = wr_hit(WRITE, ADDR, `DTP_ADDR_ASYNC_STAT);
	assign wr_flags     = wr_hit(WRITE, ADDR, `DTP_ADDR_FLAGS);

	// Control registers; bit seven is not stored
	always @(posedge CLOCK) begin
		if (RESET) begin
			timer_zero_control_ff <= `DTP_CTRL_RESET;
			timer_two_control_ff  <= `DTP_CTRL_RESET;
			async_sel_ff          <= 1'b0;
		end else begin
			if (wr_zero_ctrl) begin
				timer_zero_control_ff <= WDATA[6:0];
			end
			if (wr_two_ctrl) begin
				timer_two_control_ff <= WDATA[6:0];
			end
			if (wr_async) begin
				async_sel_ff <= WDATA[`DTP_ASYNC_SEL];
			end
		end
	end

	// ==========================================================
	// Event flags: write one or vector acknowledge clears
	assign flag_set = {two_match, two_wrap, zero_match, zero_wrap};
	assign flag_clr = VECTOR_ACK | ({4{wr_flags}} &
		{WDATA[`DTP_FLAG_T2_MATCH], WDATA[`DTP_FLAG_T2_WRAP],
		WDATA[`DTP_FLAG_T0_MATCH], WDATA[`DTP_FLAG_T0_WRAP]});

	// A set in the clearing cycle wins
	always @* begin
		nxt_flags = (flags_ff & ~flag_clr) | flag_set;
	end

	always @(posedge CLOCK) begin
		if (RESET) begin
			flags_ff <= `DTP_FLAGS_RESET;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// ==========================================================
	// Read data, one cycle after the read strobe
	always @* begin
		nxt_rdata = `DTP_BYTE_ZERO;
		if (READ) begin
			case (ADDR)
			`DTP_ADDR_T0_CTRL:  nxt_rdata = {1'b0, timer_zero_control_ff};
			`DTP_ADDR_T2_CTRL:  nxt_rdata = {1'b0, timer_two_control_ff};
			`DTP_ADDR_T0_COUNT: nxt_rdata = zero_count;
			`DTP_ADDR_T2_COUNT: nxt_rdata = two_count;
			`DTP_ADDR_T0_CMP:   nxt_rdata = zero_cmp;
			`DTP_ADDR_T2_CMP:   nxt_rdata = two_cmp;
			`DTP_ADDR_ASYNC_STAT: begin
				nxt_rdata = `DTP_BYTE_ZERO;
				nxt_rdata[`DTP_ASYNC_SEL] = async_sel_ff;
			end
			`DTP_ADDR_FLAGS: begin
				nxt_rdata = `DTP_BYTE_ZERO;
				nxt_rdata[`DTP_FLAG_T0_WRAP]  = flags_ff[0];
				nxt_rdata[`DTP_FLAG_T0_MATCH] = flags_ff[1];
				nxt_rdata[`DTP_FLAG_T2_WRAP]  = flags_ff[2];
				nxt_rdata[`DTP_FLAG_T2_MATCH] = flags_ff[3];
			end
			default: nxt_rdata = `DTP_BYTE_ZERO;
			endcase
		end
	end

	// ==========================================================
	// Registered outputs: read data and pin enables
	// Pin driven only when direction is output and a mode connects it
	always @(posedge CLOCK) begin
		if (RESET) begin
			RDATA                 <= `DTP_BYTE_ZERO;
			TIMER_ZERO_COMPARE_OE <= 1'b0;
			TIMER_TWO_COMPARE_OE  <= 1'b0;
		end else begin
			RDATA <= nxt_rdata;
			TIMER_ZERO_COMPARE_OE <= ZERO_PIN_DIR &
				(timer_zero_control_ff[`DTP_CTRL_PWM] ?
				timer_zero_control_ff[`DTP_CTRL_MODE_HI] :
				(timer_zero_control_ff[`DTP_CTRL_MODE_HI] |
				timer_zero_control_ff[`DTP_CTRL_MODE_LO]));
			TIMER_TWO_COMPARE_OE <= TWO_PIN_DIR &
				(timer_two_control_ff[`DTP_CTRL_PWM] ?
				timer_two_control_ff[`DTP_CTRL_MODE_HI] :
				(timer_two_control_ff[`DTP_CTRL_MODE_HI] |
				timer_two_control_ff[`DTP_CTRL_MODE_LO]));
		end
	end

endmodule
`default_nettype wire
